// ---- verilog/fpcp_top.v ----
// flash programming command port: mode strap, link selection, serial links
// and the command sequencer with its own flash array
// assumes all inputs are synchronous to i_ref_clk
`timescale 1ns/10ps
`include "fpcp_defs.vh"

module fpcp_top #(
   parameter MEM_AW = 10,
   parameter SEL_QUIET_CYC = `FPCP_SEL_QUIET_CYC,
   parameter [7:0] DEV_ID = `FPCP_DEV_ID,
   parameter [7:0] DEV_VER = `FPCP_DEV_VER,
   parameter [7:0] FW_VER = `FPCP_FW_VER
) (
   // clock and reset
   input wire i_ref_clk,
   input wire i_rst_b,
   // mode strap and selection pulses
   input wire i_mode_select_pin,
   // asynchronous serial channel
   input wire i_async_receive_line,
   output reg o_async_transmit_line,
   // three-wire serial channel
   input wire i_sync_serial_clock,
   input wire i_sync_serial_in,
   output reg o_sync_serial_out,
   // mode and status
   output reg o_prog_mode,
   output reg o_normal_run,
   output reg [1:0] o_link_sel,
   output reg [1:0] o_clk_src,
   output reg o_link_synced
);

   localparam [31:0] MEM_TOP = (32'h1 << MEM_AW) - 32'h1;
   localparam integer QUIET_LAST_I = SEL_QUIET_CYC - 1;
   localparam [23:0] QUIET_LAST = QUIET_LAST_I[23:0];
   localparam integer DIV_NOM_I = `FPCP_DIV_NOM;
   localparam [15:0] DIV_NOM = DIV_NOM_I[15:0];

   // flash array
   reg [7:0] mem [0:MEM_TOP];

   // ****************************************
   // mode strap and link selection
   // ****************************************
   localparam M_BOOT = 2'd0;
   localparam M_NORM = 2'd1;
   localparam M_COUNT = 2'd2;
   localparam M_RUN = 2'd3;

   reg [1:0] mode_r;
   reg mpin_d_r;
   reg [3:0] pulses_r;
   reg [23:0] quiet_r;

   // strap caught on the first edge after release, then pulses counted
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_r <= M_BOOT;
         mpin_d_r <= 1'b0;
         pulses_r <= 4'h0;
         quiet_r <= 24'h000000;
         o_prog_mode <= 1'b0;
         o_normal_run <= 1'b0;
         o_link_sel <= `FPCP_LINK_NONE;
         o_clk_src <= `FPCP_CLK_XTAL;
      end else begin
         mpin_d_r <= i_mode_select_pin;
         case (mode_r)
            M_BOOT: begin
               if (i_mode_select_pin) begin
                  mode_r <= M_COUNT;
                  o_prog_mode <= 1'b1;
               end else begin
                  mode_r <= M_NORM;
                  o_normal_run <= 1'b1;
               end
            end
            M_COUNT: begin
               // a falling edge starts one pulse; quiet time closes the count
               if (mpin_d_r && !i_mode_select_pin) begin
                  if (pulses_r != 4'hF)
                     pulses_r <= pulses_r + 4'h1;
                  quiet_r <= 24'h000000;
               end else if (quiet_r == QUIET_LAST) begin
                  mode_r <= M_RUN;
                  case (pulses_r)
                     `FPCP_PULSES_ASYNC_XTAL: begin
                        o_link_sel <= `FPCP_LINK_ASYNC;
                        o_clk_src <= `FPCP_CLK_XTAL;
                     end
                     `FPCP_PULSES_ASYNC_TOOL: begin
                        o_link_sel <= `FPCP_LINK_ASYNC;
                        o_clk_src <= `FPCP_CLK_TOOL;
                     end
                     `FPCP_PULSES_ASYNC_INT: begin
                        o_link_sel <= `FPCP_LINK_ASYNC;
                        o_clk_src <= `FPCP_CLK_INT;
                     end
                     `FPCP_PULSES_SYNC_INT: begin
                        o_link_sel <= `FPCP_LINK_SYNC;
                        o_clk_src <= `FPCP_CLK_INT;
                     end
                     default: o_link_sel <= `FPCP_LINK_BAD;
                  endcase
               end else begin
                  quiet_r <= quiet_r + 24'h000001;
               end
            end
            default: mode_r <= mode_r; // normal run and link run are final
         endcase
      end
   end

   wire uart_on = (o_link_sel == `FPCP_LINK_ASYNC);
   wire csi_on = (o_link_sel == `FPCP_LINK_SYNC);

   // ****************************************
   // async receiver with bit timing learnt from the reset command
   // ****************************************
   localparam U_IDLE = 3'd0;
   localparam U_MEAS = 3'd1;
   localparam U_CHK = 3'd2;
   localparam U_HALF = 3'd3;
   localparam U_BITS = 3'd4;
   localparam U_STOP = 3'd5;

   reg [2:0] ust_r;
   reg rxd_r;
   reg [15:0] ucnt_r;
   reg [3:0] ubit_r;
   reg [7:0] ushf_r;
   reg [15:0] div_r;
   reg baud_ok_r;
   reg u_vld_r;
   reg [7:0] u_byte_r;

   wire [15:0] div_last = div_r - 16'h0001;

   // the reset command is one low start bit then nine high bit times
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ust_r <= U_IDLE;
         rxd_r <= 1'b1;
         ucnt_r <= 16'h0000;
         ubit_r <= 4'h0;
         ushf_r <= 8'h00;
         div_r <= DIV_NOM;
         baud_ok_r <= 1'b0;
         u_vld_r <= 1'b0;
         u_byte_r <= 8'h00;
      end else begin
         rxd_r <= i_async_receive_line;
         u_vld_r <= 1'b0;
         case (ust_r)
            U_IDLE: begin
               ucnt_r <= 16'h0000;
               ubit_r <= 4'h0;
               if (uart_on && !rxd_r)
                  ust_r <= baud_ok_r ? U_HALF : U_MEAS;
            end
            U_MEAS: begin
               if (rxd_r) begin
                  ucnt_r <= 16'h0000;
                  div_r <= ucnt_r + 16'h0001;
                  ust_r <= (ucnt_r < `FPCP_DIV_MIN) ? U_IDLE : U_CHK;
               end else if (ucnt_r == 16'hFFFF) begin
                  ust_r <= U_IDLE;
               end else begin
                  ucnt_r <= ucnt_r + 16'h0001;
               end
            end
            U_CHK: begin
               if (!rxd_r) begin
                  ust_r <= U_IDLE; // not a reset command, measure again
               end else if (ucnt_r == div_last) begin
                  ucnt_r <= 16'h0000;
                  ubit_r <= ubit_r + 4'h1;
                  if (ubit_r == 4'h8) begin
                     baud_ok_r <= 1'b1;
                     u_vld_r <= 1'b1;
                     u_byte_r <= `FPCP_CMD_RESET;
                     ust_r <= U_IDLE;
                  end
               end else begin
                  ucnt_r <= ucnt_r + 16'h0001;
               end
            end
            U_HALF: begin
               if (ucnt_r == {1'b0, div_r[15:1]}) begin
                  ucnt_r <= 16'h0000;
                  ust_r <= rxd_r ? U_IDLE : U_BITS;
               end else begin
                  ucnt_r <= ucnt_r + 16'h0001;
               end
            end
            U_BITS, U_STOP: begin
               if (ucnt_r == div_last) begin
                  ucnt_r <= 16'h0000;
                  if (ust_r == U_BITS) begin
                     ushf_r <= {rxd_r, ushf_r[7:1]};
                     ubit_r <= ubit_r + 4'h1;
                     if (ubit_r == 4'h7)
                        ust_r <= U_STOP;
                  end else begin
                     ust_r <= U_IDLE;
                     // a bad stop bit drops the learnt timing
                     if (rxd_r) begin
                        u_vld_r <= 1'b1;
                        u_byte_r <= ushf_r;
                     end else begin
                        baud_ok_r <= 1'b0;
                     end
                  end
               end else begin
                  ucnt_r <= ucnt_r + 16'h0001;
               end
            end
            default: ust_r <= U_IDLE;
         endcase
      end
   end

   // ****************************************
   // async transmitter
   // ****************************************
   reg tx_go_r;
   reg [7:0] tx_data_r;
   reg [9:0] utx_shf_r;
   reg [3:0] utx_bits_r;
   reg [15:0] utx_cnt_r;

   // start, eight data bits lsb first, stop; the extra step holds the stop
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_async_transmit_line <= 1'b1;
         utx_shf_r <= 10'h3FF;
         utx_bits_r <= 4'h0;
         utx_cnt_r <= 16'h0000;
      end else if (utx_bits_r == 4'h0) begin
         if (tx_go_r && uart_on) begin
            utx_shf_r <= {1'b1, tx_data_r, 1'b0};
            utx_bits_r <= 4'hB;
            utx_cnt_r <= 16'h0000;
         end
      end else if (utx_cnt_r == 16'h0000) begin
         o_async_transmit_line <= utx_shf_r[0];
         utx_shf_r <= {1'b1, utx_shf_r[9:1]};
         utx_cnt_r <= div_last;
         utx_bits_r <= utx_bits_r - 4'h1;
      end else begin
         utx_cnt_r <= utx_cnt_r - 16'h0001;
      end
   end

   // ****************************************
   // three-wire link: sample on rising, shift out on falling, msb first
   // ****************************************
   reg sck_r;
   reg sck_p_r;
   reg si_r;
   reg [2:0] cbit_r;
   reg [6:0] cshf_r;
   reg c_vld_r;
   reg [7:0] c_byte_r;
   reg [7:0] ctx_byte_r;
   reg ctx_busy_r;
   reg ctx_pend_r;

   wire sck_rise = sck_r && !sck_p_r;
   wire sck_fall = !sck_r && sck_p_r;

   // oversampled at 50 MHz, so every rate up to 2.5 MHz is followed
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sck_r <= 1'b1;
         sck_p_r <= 1'b1;
         si_r <= 1'b1;
         cbit_r <= 3'h0;
         cshf_r <= 7'h00;
         c_vld_r <= 1'b0;
         c_byte_r <= 8'h00;
         ctx_byte_r <= 8'hFF;
         ctx_busy_r <= 1'b0;
         ctx_pend_r <= 1'b0;
         o_sync_serial_out <= 1'b1;
      end else begin
         sck_r <= i_sync_serial_clock;
         sck_p_r <= sck_r;
         si_r <= i_sync_serial_in;
         c_vld_r <= 1'b0;
         if (csi_on) begin
            if (sck_rise) begin
               cshf_r <= {cshf_r[5:0], si_r};
               cbit_r <= cbit_r + 3'h1;
               if (cbit_r == 3'h7) begin
                  c_vld_r <= 1'b1;
                  c_byte_r <= {cshf_r, si_r};
                  if (!ctx_pend_r)
                     ctx_busy_r <= 1'b0;
               end
            end else if (sck_fall) begin
               // first fall of a byte keeps the bit 7 shown while idle
               if (cbit_r != 3'h0 && ctx_busy_r && !ctx_pend_r)
                  o_sync_serial_out <= ctx_byte_r[3'h7 - cbit_r];
               else if (cbit_r != 3'h0 || !ctx_busy_r)
                  o_sync_serial_out <= 1'b1;
            end else if (ctx_pend_r && cbit_r == 3'h0) begin
               o_sync_serial_out <= ctx_byte_r[7];
               ctx_pend_r <= 1'b0;
            end
            if (tx_go_r) begin
               ctx_byte_r <= tx_data_r;
               ctx_busy_r <= 1'b1;
               ctx_pend_r <= 1'b1;
            end
         end
      end
   end

   wire rx_vld = u_vld_r || c_vld_r;
   wire [7:0] rx_byte = c_vld_r ? c_byte_r : u_byte_r;
   wire tx_busy = uart_on ? (utx_bits_r != 4'h0) : ctx_busy_r;

   // ****************************************
   // command sequencer
   // ****************************************
   localparam S_CMD = 3'd0;
   localparam S_ARG = 3'd1;
   localparam S_ADH = 3'd2;
   localparam S_ADL = 3'd3;
   localparam S_LEN = 3'd4;
   localparam S_DATA = 3'd5;
   localparam S_SCAN = 3'd6;
   localparam S_RESP = 3'd7;

   reg [2:0] st_r;
   reg [7:0] cmd_r;
   reg [15:0] addr_r;
   reg [15:0] left_r;
   reg ok_r;
   reg [15:0] csum_r;
   reg [7:0] sec_r;
   reg [7:0] freq_r;
   reg [23:0] resp_r;
   reg [1:0] rcnt_r;

   wire [7:0] rd_byte = mem[addr_r[MEM_AW-1:0]];
   wire is_erase = (cmd_r == `FPCP_CMD_CHIP_ERASE) || (cmd_r == `FPCP_CMD_BLOCK_ERASE);
   wire [7:0] ack_nak = ok_r ? `FPCP_RSP_ACK : `FPCP_RSP_NAK;

   // only bytes from the programmer start work; replies go out byte by byte
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= S_CMD;
         cmd_r <= 8'h00;
         addr_r <= 16'h0000;
         left_r <= 16'h0000;
         ok_r <= 1'b0;
         csum_r <= 16'h0000;
         sec_r <= 8'h00;
         freq_r <= 8'h00;
         resp_r <= 24'h000000;
         rcnt_r <= 2'h0;
         tx_go_r <= 1'b0;
         tx_data_r <= 8'h00;
         o_link_synced <= 1'b0;
      end else begin
         tx_go_r <= 1'b0;
         case (st_r)
            S_CMD: begin
               if (rx_vld) begin
                  cmd_r <= rx_byte;
                  ok_r <= 1'b1;
                  csum_r <= 16'h0000;
                  st_r <= S_RESP;
                  rcnt_r <= 2'h1;
                  resp_r <= {`FPCP_RSP_NAK, 16'h0000};
                  if (rx_byte == `FPCP_CMD_RESET) begin
                     o_link_synced <= 1'b1;
                     resp_r <= {`FPCP_RSP_ACK, 16'h0000};
                  end else if (o_link_synced) begin
                     case (rx_byte)
                        `FPCP_CMD_CHIP_ERASE: begin
                           if (!sec_r[`FPCP_SEC_NO_CHIP]) begin
                              addr_r <= 16'h0000;
                              left_r <= MEM_TOP[15:0];
                              st_r <= S_SCAN;
                           end
                        end
                        `FPCP_CMD_STATUS: begin
                           rcnt_r <= 2'h2;
                           resp_r <= {`FPCP_RSP_ACK, o_link_synced, o_link_sel,
                                      o_clk_src, sec_r[2:0], 8'h00};
                        end
                        `FPCP_CMD_SIGNATURE: begin
                           rcnt_r <= 2'h3;
                           resp_r <= {`FPCP_RSP_ACK, DEV_ID, MEM_AW[7:0]};
                        end
                        `FPCP_CMD_VERSION: begin
                           rcnt_r <= 2'h3;
                           resp_r <= {`FPCP_RSP_ACK, DEV_VER, FW_VER};
                        end
                        `FPCP_CMD_SECURITY_SET, `FPCP_CMD_FREQ_SET:
                           st_r <= S_ARG;
                        `FPCP_CMD_VERIFY, `FPCP_CMD_BLOCK_ERASE, `FPCP_CMD_BLANK_CHECK,
                        `FPCP_CMD_PROGRAM, `FPCP_CMD_CHECKSUM:
                           st_r <= S_ADH;
                        default: st_r <= S_RESP;
                     endcase
                  end
               end
            end
            S_ARG: begin
               if (rx_vld) begin
                  if (cmd_r == `FPCP_CMD_SECURITY_SET)
                     sec_r <= sec_r | rx_byte;
                  else
                     freq_r <= rx_byte;
                  resp_r <= {`FPCP_RSP_ACK, 16'h0000};
                  rcnt_r <= 2'h1;
                  st_r <= S_RESP;
               end
            end
            S_ADH: begin
               if (rx_vld) begin
                  addr_r <= {rx_byte, 8'h00};
                  st_r <= S_ADL;
               end
            end
            S_ADL: begin
               if (rx_vld) begin
                  addr_r <= {addr_r[15:8], rx_byte};
                  st_r <= S_LEN;
               end
            end
            S_LEN: begin
               if (rx_vld) begin
                  left_r <= {8'h00, rx_byte}; // region is length byte plus one
                  if (cmd_r == `FPCP_CMD_PROGRAM) begin
                     ok_r <= !sec_r[`FPCP_SEC_NO_WRITE];
                     st_r <= S_DATA;
                  end else if (cmd_r == `FPCP_CMD_VERIFY) begin
                     st_r <= S_DATA;
                  end else if (cmd_r == `FPCP_CMD_BLOCK_ERASE &&
                               (sec_r[`FPCP_SEC_NO_BLOCK] || sec_r[`FPCP_SEC_NO_WRITE])) begin
                     resp_r <= {`FPCP_RSP_NAK, 16'h0000};
                     rcnt_r <= 2'h1;
                     st_r <= S_RESP;
                  end else begin
                     st_r <= S_SCAN;
                  end
               end
            end
            S_DATA: begin
               if (rx_vld) begin
                  if (cmd_r == `FPCP_CMD_PROGRAM && ok_r)
                     mem[addr_r[MEM_AW-1:0]] <= rx_byte;
                  if (cmd_r == `FPCP_CMD_VERIFY && rd_byte != rx_byte)
                     ok_r <= 1'b0;
                  addr_r <= addr_r + 16'h0001;
                  left_r <= left_r - 16'h0001;
                  if (left_r == 16'h0000) begin
                     resp_r <= {ack_nak, 16'h0000};
                     rcnt_r <= 2'h1;
                     st_r <= S_RESP;
                  end
               end
            end
            S_SCAN: begin
               // one flash byte per cycle over the region
               if (is_erase)
                  mem[addr_r[MEM_AW-1:0]] <= `FPCP_ERASED;
               if (cmd_r == `FPCP_CMD_BLANK_CHECK && rd_byte != `FPCP_ERASED)
                  ok_r <= 1'b0;
               csum_r <= csum_r - {8'h00, rd_byte};
               addr_r <= addr_r + 16'h0001;
               left_r <= left_r - 16'h0001;
               if (left_r == 16'h0000) begin
                  st_r <= S_RESP;
                  rcnt_r <= 2'h1;
                  resp_r <= {ack_nak, 16'h0000};
                  if (cmd_r == `FPCP_CMD_CHIP_ERASE)
                     sec_r <= sec_r & ~8'h06; // chip erase lifts block and write locks
                  if (cmd_r == `FPCP_CMD_CHECKSUM) begin
                     rcnt_r <= 2'h3;
                     resp_r <= {`FPCP_RSP_ACK, csum_r - {8'h00, rd_byte}};
                  end
               end
            end
            S_RESP: begin
               // one byte handed over, then wait for the link to drain it
               if (!tx_go_r && !tx_busy) begin
                  if (rcnt_r == 2'h0) begin
                     st_r <= S_CMD;
                  end else begin
                     tx_go_r <= 1'b1;
                     tx_data_r <= resp_r[23:16];
                     resp_r <= {resp_r[15:0], 8'h00};
                     rcnt_r <= rcnt_r - 2'h1;
                  end
               end
            end
            default: st_r <= S_CMD;
         endcase
      end
   end

endmodule

// ---- verilog/fpcp_defs.vh ----
// constants for the flash programming command port
// assumes a 50 MHz reference clock and one command port per device
`ifndef FPCP_DEFS_VH
`define FPCP_DEFS_VH

// ****************************************
// timing
// ****************************************
`define FPCP_REF_HZ 50000000
`define FPCP_BAUD_BPS 115200
`define FPCP_DIV_NOM (`FPCP_REF_HZ / `FPCP_BAUD_BPS)
`define FPCP_DIV_MIN 16'h0004
`define FPCP_SEL_QUIET_US 100
`define FPCP_SEL_QUIET_CYC (`FPCP_SEL_QUIET_US * (`FPCP_REF_HZ / 1000000))
`define FPCP_CSI_MIN_HZ 2400
`define FPCP_CSI_MAX_HZ 2500000

// ****************************************
// link selection pulse counts and codes
// ****************************************
`define FPCP_PULSES_ASYNC_XTAL 4'h0
`define FPCP_PULSES_ASYNC_TOOL 4'h3
`define FPCP_PULSES_ASYNC_INT 4'h5
`define FPCP_PULSES_SYNC_INT 4'h8
`define FPCP_LINK_NONE 2'h0
`define FPCP_LINK_ASYNC 2'h1
`define FPCP_LINK_SYNC 2'h2
`define FPCP_LINK_BAD 2'h3
`define FPCP_CLK_XTAL 2'h0
`define FPCP_CLK_TOOL 2'h1
`define FPCP_CLK_INT 2'h2

// ****************************************
// command and response bytes
// ****************************************
`define FPCP_CMD_RESET 8'hFF
`define FPCP_CMD_VERIFY 8'h13
`define FPCP_CMD_CHIP_ERASE 8'h20
`define FPCP_CMD_BLOCK_ERASE 8'h22
`define FPCP_CMD_BLANK_CHECK 8'h32
`define FPCP_CMD_PROGRAM 8'h40
`define FPCP_CMD_STATUS 8'h70
`define FPCP_CMD_FREQ_SET 8'h90
`define FPCP_CMD_SECURITY_SET 8'hA0
`define FPCP_CMD_CHECKSUM 8'hB0
`define FPCP_CMD_SIGNATURE 8'hC0
`define FPCP_CMD_VERSION 8'hC5
`define FPCP_RSP_ACK 8'h06
`define FPCP_RSP_NAK 8'h15
`define FPCP_ERASED 8'hFF

// ****************************************
// security bits and identity (identity values arbitrary)
// ****************************************
`define FPCP_SEC_NO_CHIP 0
`define FPCP_SEC_NO_BLOCK 1
`define FPCP_SEC_NO_WRITE 2
`define FPCP_DEV_ID 8'h5A
`define FPCP_DEV_VER 8'h01
`define FPCP_FW_VER 8'h01

`endif

// ---- test/fpcp_monitor.sv ----
// checker on the command port pins
// assumes one clock and an active-low async reset
`timescale 1ns/10ps
module fpcp_monitor (
   // clock and reset
   input wire i_ref_clk,
   input wire i_rst_b,
   // watched pins
   input wire i_mode_select_pin,
   input wire o_async_transmit_line,
   input wire o_sync_serial_out,
   input wire o_prog_mode,
   input wire o_normal_run,
   input wire [1:0] o_link_sel,
   input wire [1:0] o_clk_src,
   input wire o_link_synced
);
   // ****
   // checks
   // ****
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   strap_prog_a: assert property ($rose(i_rst_b) && i_mode_select_pin |=> o_prog_mode)
      else $error("strap high missed");
   strap_norm_a: assert property ($rose(i_rst_b) && !i_mode_select_pin |=> o_normal_run)
      else $error("strap low missed");
   sel_quiet_a: assert property ($fell(i_mode_select_pin) && o_prog_mode
      && o_link_sel == 2'h0 |=> (o_link_sel == 2'h0) [*8]) else $error("link picked mid pulses");
   sel_time_a: assert property ($rose(o_prog_mode) |-> ##[1:400] o_link_sel != 2'h0)
      else $error("link never picked");
   link_hold_a: assert property (o_link_sel != 2'h0
      |=> $stable(o_link_sel) && $stable(o_clk_src)) else $error("link changed");
   wire_clk_a: assert property (o_link_sel == 2'h2 |-> o_clk_src == 2'h2)
      else $error("three-wire off internal clock");
   norm_quiet_a: assert property (o_normal_run |-> o_async_transmit_line
      && o_sync_serial_out && o_link_sel == 2'h0 && !o_link_synced)
      else $error("normal run pins moved");
   resp_only_a: assert property (o_link_sel != 2'h1 |-> o_async_transmit_line)
      else $error("transmit without link");
   start_bit_a: assert property ($fell(o_async_transmit_line)
      |=> !o_async_transmit_line [*3]) else $error("start bit short");
   cover property (o_prog_mode);
   cover property (o_normal_run);
   cover property (o_link_synced);
endmodule
bind fpcp_top fpcp_monitor u_fpcp_monitor (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
   .i_mode_select_pin(i_mode_select_pin), .o_async_transmit_line(o_async_transmit_line),
   .o_sync_serial_out(o_sync_serial_out), .o_prog_mode(o_prog_mode),
   .o_normal_run(o_normal_run), .o_link_sel(o_link_sel), .o_clk_src(o_clk_src),
   .o_link_synced(o_link_synced));

// ---- test/fpcp_prog_model.sv ----
// programmer model: strap, selection pulses, 8N1 bytes
// assumes the device learns its bit time from the reset byte
`timescale 1ns/10ps
module fpcp_prog_model #(
   parameter BT = 16
) (
   // clock
   input wire i_ref_clk,
   // device side
   input wire i_async_transmit_line,
   input wire i_sync_serial_out,
   output reg o_mode_select_pin,
   output reg o_async_receive_line,
   output reg o_sync_serial_clock,
   output reg o_sync_serial_in
);
   // idle levels
   initial begin
      o_mode_select_pin = 1'b0;
      o_async_receive_line = 1'b1;
      o_sync_serial_clock = 1'b1;
      o_sync_serial_in = 1'b1;
   end
   // low-going pulses after the strap
   task pulses(input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            @(negedge i_ref_clk) o_mode_select_pin = 1'b0;
            repeat (2) @(negedge i_ref_clk);
            o_mode_select_pin = 1'b1;
            @(negedge i_ref_clk);
         end
      end
   endtask
   // one command frame, lsb first
   task send(input [7:0] b);
      reg [9:0] f;
      integer i;
      begin
         f = {1'b1, b, 1'b0};
         for (i = 0; i < 10; i = i + 1) begin
            @(negedge i_ref_clk) o_async_receive_line = f[i];
            repeat (BT - 1) @(negedge i_ref_clk);
         end
      end
   endtask
   // one response frame, bounded wait, mid-bit samples
   task recv(output [7:0] b, output ok);
      integer i;
      begin
         ok = 1'b0;
         for (i = 0; i < 4000 && !ok; i = i + 1) begin
            @(negedge i_ref_clk);
            ok = !i_async_transmit_line;
         end
         repeat (BT / 2) @(negedge i_ref_clk);
         for (i = 0; i < 8; i = i + 1) begin
            repeat (BT) @(negedge i_ref_clk);
            b[i] = i_async_transmit_line;
         end
         repeat (BT) @(negedge i_ref_clk);
      end
   endtask
   // one three-wire byte each way, msb first, 2.5 MHz clock
   task xfer(input [7:0] b, output [7:0] r);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            @(negedge i_ref_clk) o_sync_serial_clock = 1'b0;
            o_sync_serial_in = b[i];
            repeat (10) @(negedge i_ref_clk);
            o_sync_serial_clock = 1'b1;
            r[i] = i_sync_serial_out;
            repeat (9) @(negedge i_ref_clk);
         end
      end
   endtask
endmodule

// ---- test/fpcp_top_test.sv ----
// bench: strap, link choice, then commands over the async link
// assumes the programmer model drives mode pin and serial lines
`timescale 1ns/10ps
`include "fpcp_defs.vh"
module fpcp_top_test;
   reg i_ref_clk = 1'b0;
   reg i_rst_b = 1'b0;
   wire mode_w, rx_w, tx_w, pm_w, nr_w, syn_w, sck_w, si_w, so_w;
   wire [1:0] ls_w, cs_w;
   integer err_total = 0;
   integer num_checks = 0;
   integer seed = 28;
   integer k, n;
   reg [7:0] d;
   // clock, design, programmer
   always #10 i_ref_clk = ~i_ref_clk;
   fpcp_top #(.SEL_QUIET_CYC(50)) u_fpcp_top (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
      .i_mode_select_pin(mode_w), .i_async_receive_line(rx_w), .o_async_transmit_line(tx_w),
      .i_sync_serial_clock(sck_w), .i_sync_serial_in(si_w), .o_sync_serial_out(so_w),
      .o_prog_mode(pm_w), .o_normal_run(nr_w), .o_link_sel(ls_w), .o_clk_src(cs_w),
      .o_link_synced(syn_w));
   fpcp_prog_model u_fpcp_prog_model (.i_ref_clk(i_ref_clk), .i_async_transmit_line(tx_w),
      .o_mode_select_pin(mode_w), .o_async_receive_line(rx_w), .i_sync_serial_out(so_w),
      .o_sync_serial_clock(sck_w), .o_sync_serial_in(si_w));
   // byte compare
   task chk(input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // verdict
   task end_sim;
      begin
         $display("checks=%0d mismatches=%0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // reset with strap level st, then n pulses and the quiet time
   task start(input st, input integer n);
      begin
         @(negedge i_ref_clk) i_rst_b = 1'b0;
         u_fpcp_prog_model.o_mode_select_pin = st;
         repeat (20) @(negedge i_ref_clk);
         i_rst_b = 1'b1;
         repeat (2) @(negedge i_ref_clk);
         u_fpcp_prog_model.pulses(n);
         repeat (80) @(negedge i_ref_clk);
      end
   endtask
   // send ntx bytes, compare nrx response bytes
   task xact(input [39:0] tx, input integer ntx, input [23:0] rx, input integer nrx);
      reg [7:0] b;
      reg ok;
      integer i;
      begin
         for (i = ntx - 1; i >= 0; i = i - 1)
            u_fpcp_prog_model.send(tx[8*i +: 8]);
         for (i = nrx - 1; i >= 0; i = i - 1) begin
            u_fpcp_prog_model.recv(b, ok);
            if (ok !== 1'b1) begin
               err_total = err_total + 1;
               $display("FAIL t=%0t got=%h exp=%h", $time, b, rx[8*i +: 8]);
               end_sim;
            end else
               chk(b, rx[8*i +: 8]);
         end
      end
   endtask
   // main sequence
   initial begin
      start(1'b0, 0);
      chk({7'h0, nr_w}, 8'h01);
      chk({7'h0, pm_w}, 8'h00);
      for (k = 0; k < 5; k = k + 1) begin
         n = (20'h85320 >> (16 - 4 * k)) & 15;
         start(1'b1, n);
         chk({7'h0, pm_w}, 8'h01);
         chk({6'h0, ls_w}, (n == 8) ? 8'h02 : (n == 2) ? 8'h03 : 8'h01);
         if (n != 2)
            chk({6'h0, cs_w}, (n == 0) ? 8'h00 : (n == 3) ? 8'h01 : 8'h02);
         if (n == 8) begin
            u_fpcp_prog_model.xfer(8'hFF, d);
            u_fpcp_prog_model.xfer(8'hFF, d);
            chk(d, 8'h06);
         end
      end
      $display("selection test done");
      d = 8'($random(seed));
      xact(40'hFF, 1, 24'h06, 1);
      chk({7'h0, syn_w}, 8'h01);
      xact({32'h40001000, d}, 5, 24'h06, 1);
      xact(40'hB0001000, 4, {8'h06, 16'h0 - {8'h0, d}}, 3);
      xact(40'h20, 1, 24'h06, 1);
      xact(40'h32001000, 4, 24'h06, 1);
      xact(40'hB0001000, 4, 24'h06FF01, 3);
      xact(40'h13001000FF, 5, 24'h06, 1);
      xact(40'hC5, 1, {8'h06, `FPCP_DEV_VER, `FPCP_FW_VER}, 3);
      xact(40'hC0, 1, {8'h06, `FPCP_DEV_ID, 8'h0A}, 3);
      xact(40'h00, 1, 24'h15, 1);
      xact({24'h0, 8'hA0, d}, 2, 24'h06, 1);
      xact(40'h900A, 2, 24'h06, 1);
      xact(40'h70, 1, {8'h06, 1'b1, 2'h1, 2'h0, d[2:0]}, 2);
      $display("command test done");
      end_sim;
   end
endmodule
